//--- ssimon_core.sv
// Function
// [RULE1] master clocks at 70 kHz or faster; slower counts as absent or invalid
// [RULE2] steady green only with element in range and a valid clock
// [RULE3] steady yellow when no serial clock is detected
// [RULE4] steady red when element is absent, whatever the clock does
// [RULE5] position field is zero in every frame while no element is seen
// [RULE6] sync mode, reads not synchronised: green with short yellow flashes
// [RULE7] pulse count differs from data length: yellow with short red flashes
// [RULE8] master should lengthen its update interval on sync loss
// [RULE9] after reset the gain is calibrated to the element present
// [RULE10] master alone sets clock rate and frame length; device follows
// [RULE11] internal fault flashes red and overrides every other indication
// [RULE12] position refreshed at length-dependent interval, held stable between
//
// Local design decisions: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`include "ssimon_defs.svh"

module ssimon_core #(
    parameter int               POS_W         = 24,
    parameter logic [21:0]      LOSS_CYC      = 22'(`SSIMON_CLK_LOSS_MS * `SSIMON_CLK_MHZ * 1000),
    parameter logic [27:0]      FLASH_PER_CYC = 28'(`SSIMON_FLASH_PER_MS * `SSIMON_CLK_MHZ * 1000),
    parameter logic [27:0]      FLASH_ON_CYC  = 28'(`SSIMON_FLASH_ON_MS * `SSIMON_CLK_MHZ * 1000),
    parameter logic [`SSIMON_UPD_W-1:0] UPD0_CYC = `SSIMON_UPD_W'(`SSIMON_UPD0_US * `SSIMON_CLK_MHZ),
    parameter logic [`SSIMON_UPD_W-1:0] UPD1_CYC = `SSIMON_UPD_W'(`SSIMON_UPD1_US * `SSIMON_CLK_MHZ),
    parameter logic [`SSIMON_UPD_W-1:0] UPD2_CYC = `SSIMON_UPD_W'(`SSIMON_UPD2_US * `SSIMON_CLK_MHZ),
    parameter logic [`SSIMON_UPD_W-1:0] UPD3_CYC = `SSIMON_UPD_W'(`SSIMON_UPD3_US * `SSIMON_CLK_MHZ),
    parameter logic [`SSIMON_UPD_W-1:0] UPD4_CYC = `SSIMON_UPD_W'(`SSIMON_UPD4_US * `SSIMON_CLK_MHZ)
) (
    // clock and reset
    input  logic                i_clk_sys,
    input  logic                i_rst,
    // serial link
    input  logic                i_ssi_clk,
    output logic                o_ssi_data,
    // measuring front end
    input  logic                i_elem_present,
    input  logic [7:0]          i_sig_level,
    input  logic [POS_W-1:0]    i_meas_pos,
    input  logic                i_fault,
    // indicator and gain
    output logic                o_led_red,
    output logic                o_led_green,
    output logic [7:0]          o_gain,
    // register port
    input  logic [7:0]          i_addr,
    input  logic [31:0]         i_wdata,
    input  logic                i_wr,
    input  logic                i_rd,
    output logic [31:0]         o_rdata,
    output logic                o_irq
);

    localparam logic [11:0] GAP_CYC = 12'(`SSIMON_GAP_CYC);

    ssimon_pkg::ssimon_core_s r_q;
    ssimon_pkg::ssimon_core_s r_d;

    ssimon_upd_if upd ();

    logic                     rise;
    logic                     fall;
    logic                     fstart;
    logic                     fend;
    logic                     flash_on;
    logic                     flash_half;
    logic [`SSIMON_NIRQ-1:0]  ev;
    logic [`SSIMON_NIRQ-1:0]  clr;

    assign upd.len_sel  = r_q.len_sel;
    assign upd.meas_pos = `SSIMON_SR_W'(i_meas_pos);

    ssimon_update #(
        .UPD0_CYC (UPD0_CYC),
        .UPD1_CYC (UPD1_CYC),
        .UPD2_CYC (UPD2_CYC),
        .UPD3_CYC (UPD3_CYC),
        .UPD4_CYC (UPD4_CYC)
    ) u_update (
        .i_clk_sys (i_clk_sys),
        .i_rst     (i_rst),
        .bus       (upd.upd)
    );

    ////////////////////////////////////////////////////////////////////////////
    // edge finding on the synchronised clock, s1 feeds only s2
    assign rise   = r_q.clk_s2 & ~r_q.clk_s3;
    assign fall   = ~r_q.clk_s2 & r_q.clk_s3;
    assign fstart = fall & ~r_q.in_frame;
    // [RULE1] idle-high gap past one slow period
    assign fend   = r_q.in_frame & r_q.clk_s2 & (r_q.gap_cnt >= GAP_CYC);

    assign flash_on   = r_q.flash_cnt < FLASH_ON_CYC;
    assign flash_half = r_q.flash_cnt < (FLASH_PER_CYC >> 1);

    always_comb begin
        r_d = r_q;
        ev  = '0;
        clr = '0;

        // pin synchronisers
        r_d.clk_s1  = i_ssi_clk;
        r_d.clk_s2  = r_q.clk_s1;
        r_d.clk_s3  = r_q.clk_s2;
        r_d.elem_s1 = i_elem_present;
        r_d.elem_s2 = r_q.elem_s1;
        r_d.elem_q  = r_q.elem_s2;
        r_d.fault_q = i_fault;

        // [RULE9] gain capture after reset
        if (r_q.cal == ssimon_pkg::CAL_WAIT && r_q.elem_q) begin
            r_d.gain = i_sig_level;
            r_d.cal  = ssimon_pkg::CAL_DONE;
        end

        // [RULE3] clock presence watchdog
        if (rise | fall) begin
            r_d.loss_cnt = '0;
            r_d.clk_ok   = 1'b1;
        end else if (r_q.loss_cnt >= LOSS_CYC - 22'(1)) begin
            r_d.clk_ok = 1'b0;
        end else begin
            r_d.loss_cnt = r_q.loss_cnt + 22'(1);
        end

        r_d.gap_cnt = (rise | fall) ? '0 : r_q.gap_cnt + {11'h000, ~&r_q.gap_cnt};

        // update counting between reads
        if (upd.stb && r_q.upd_cnt != 2'h3) begin
            r_d.upd_cnt = r_q.upd_cnt + 2'h1;
        end

        // [RULE10] frame length follows the master
        if (fstart) begin
            r_d.in_frame  = 1'b1;
            r_d.pulse_cnt = '0;
            r_d.data      = 1'b0;
            // [RULE5] zero position without element
            r_d.sr = r_q.elem_q ? (upd.held_pos << (7'(`SSIMON_SR_W) - {1'b0, r_q.data_len}))
                                : '0;
            // [RULE6] exactly one refresh per read
            r_d.upd_cnt = {1'b0, upd.stb};
            if (r_q.sync_mode) begin
                r_d.sync_err = (r_q.upd_cnt != 2'h1);
                ev[`SSIMON_EV_SYNC] = (r_q.upd_cnt != 2'h1);
            end else begin
                r_d.sync_err = 1'b0;
            end
        end else if (rise && r_q.in_frame) begin
            r_d.data      = r_q.sr[`SSIMON_SR_W-1];
            r_d.sr        = r_q.sr << 1;
            r_d.pulse_cnt = r_q.pulse_cnt + {6'h00, ~&r_q.pulse_cnt};
        end else if (fend) begin
            r_d.in_frame = 1'b0;
            r_d.data     = 1'b1;
            // [RULE7] pulse count check at frame end
            r_d.len_err = (r_q.pulse_cnt != {1'b0, r_q.data_len});
            ev[`SSIMON_EV_LEN] = (r_q.pulse_cnt != {1'b0, r_q.data_len});
        end

        ev[`SSIMON_EV_CLK]   = r_q.clk_ok & ~r_d.clk_ok;
        ev[`SSIMON_EV_ELEM]  = ~r_q.elem_s2 & r_q.elem_q;
        ev[`SSIMON_EV_FAULT] = i_fault & ~r_q.fault_q;

        r_d.flash_cnt = (r_q.flash_cnt >= FLASH_PER_CYC - 28'(1)) ? '0
                                                                 : r_q.flash_cnt + 28'(1);

        // indicator priority, fault first
        if (r_q.fault_q) begin
            // [RULE11] fault overrides all
            r_d.led_r = flash_half;
            r_d.led_g = 1'b0;
        end else if (!r_q.elem_q) begin
            // [RULE4] red, no element
            r_d.led_r = 1'b1;
            r_d.led_g = 1'b0;
        end else if (!r_q.clk_ok) begin
            // [RULE3] yellow, no clock
            r_d.led_r = 1'b1;
            r_d.led_g = 1'b1;
        end else if (r_q.len_err) begin
            // [RULE7] yellow, red flash
            r_d.led_r = 1'b1;
            r_d.led_g = ~flash_on;
        end else if (r_q.sync_mode && r_q.sync_err) begin
            // [RULE6] green, yellow flash
            r_d.led_r = flash_on;
            r_d.led_g = 1'b1;
        end else begin
            // [RULE2] steady green
            r_d.led_r = 1'b0;
            r_d.led_g = 1'b1;
        end

        // register writes
        if (i_wr) begin
            case (i_addr)
                `SSIMON_A_CTRL: begin
                    r_d.sync_mode = i_wdata[0];
                    r_d.len_sel   = i_wdata[3:1];
                end
                `SSIMON_A_DLEN: r_d.data_len = i_wdata[5:0];
                `SSIMON_A_IEN:  r_d.irq_en   = i_wdata[`SSIMON_NIRQ-1:0];
                `SSIMON_A_ICLR: clr          = i_wdata[`SSIMON_NIRQ-1:0];
                default: ;
            endcase
        end

        // a new event beats a clear in the same cycle
        r_d.irq_stat = (r_q.irq_stat & ~clr) | ev;
        r_d.irq      = |(r_d.irq_stat & r_d.irq_en);

        r_d.rd_data = '0;
        if (i_rd) begin
            case (i_addr)
                `SSIMON_A_CTRL:  r_d.rd_data = {28'h000_0000, r_q.len_sel, r_q.sync_mode};
                `SSIMON_A_DLEN:  r_d.rd_data = {26'h000_0000, r_q.data_len};
                `SSIMON_A_STATE: r_d.rd_data = {16'h0000, r_q.gain, r_q.cal,
                                                r_q.in_frame, r_q.sync_err, r_q.len_err,
                                                r_q.clk_ok, r_q.elem_q, r_q.led_g, r_q.led_r};
                `SSIMON_A_ISTAT: r_d.rd_data = 32'(r_q.irq_stat);
                `SSIMON_A_IEN:   r_d.rd_data = 32'(r_q.irq_en);
                `SSIMON_A_POS:   r_d.rd_data = upd.held_pos;
                default:         r_d.rd_data = '0;
            endcase
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            r_q          <= '0;
            r_q.cal      <= ssimon_pkg::CAL_WAIT;
            r_q.data     <= 1'b1;
            // pin idles high; a low start would fake a clock edge after reset
            r_q.clk_s1   <= 1'b1;
            r_q.clk_s2   <= 1'b1;
            r_q.clk_s3   <= 1'b1;
            r_q.data_len <= `SSIMON_DLEN_RST;
        end else begin
            r_q <= r_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    assign o_ssi_data  = r_q.data;
    assign o_led_red   = r_q.led_r;
    assign o_led_green = r_q.led_g;
    assign o_gain      = r_q.gain;
    assign o_rdata     = r_q.rd_data;
    assign o_irq       = r_q.irq;

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);

    a_zero_pos: assert property (fstart && !r_q.elem_q |=> r_q.sr == '0) // [RULE5]
        else $error("nonzero position loaded without element");

    a_red_no_elem: assert property (!r_q.elem_q && !r_q.fault_q |=> // [RULE4]
        o_led_red && !o_led_green)
        else $error("no element but indicator not red");

    a_green_valid: assert property (o_led_green && !o_led_red |-> // [RULE2]
        $past(r_q.elem_q) && $past(r_q.clk_ok))
        else $error("green shown without element and clock");

    a_yellow_noclk: assert property (r_q.elem_q && !r_q.clk_ok && !r_q.fault_q |=> // [RULE3]
        o_led_red && o_led_green)
        else $error("clock lost but indicator not yellow");

    a_fault_over: assert property (r_q.fault_q |=> !o_led_green && // [RULE11]
        (o_led_red == $past(flash_half)))
        else $error("fault indication not shown");

    a_len_flash: assert property (r_q.elem_q && r_q.clk_ok && r_q.len_err && // [RULE7]
        !r_q.fault_q |=> o_led_red && (o_led_green == !$past(flash_on)))
        else $error("length mismatch indication wrong");

    a_sync_flash: assert property (r_q.elem_q && r_q.clk_ok && !r_q.len_err && // [RULE6]
        r_q.sync_mode && r_q.sync_err && !r_q.fault_q |=>
        o_led_green && (o_led_red == $past(flash_on)))
        else $error("sync loss indication wrong");

    a_gain_cal: assert property (r_q.cal == ssimon_pkg::CAL_WAIT && r_q.elem_q |=> // [RULE9]
        r_q.cal == ssimon_pkg::CAL_DONE && o_gain == $past(i_sig_level))
        else $error("gain not captured on first element");

    a_frame_end: assert property (fend |=> !r_q.in_frame && o_ssi_data // [RULE1]
        ##1 !r_q.in_frame)
        else $error("frame not closed after idle gap");

    a_irq_level: assert property (|(r_q.irq_stat & r_q.irq_en) |-> o_irq)
        else $error("enabled status without interrupt");

    c_frame_ok: cover property (fend && r_q.pulse_cnt == {1'b0, r_q.data_len});
    c_len_err: cover property (ev[`SSIMON_EV_LEN]);
    c_sync_err: cover property (ev[`SSIMON_EV_SYNC]);
    c_clk_lost: cover property (ev[`SSIMON_EV_CLK]);
    c_elem_lost: cover property (ev[`SSIMON_EV_ELEM]);

endmodule : ssimon_core

//--- ssimon_defs.svh
`ifndef SSIMON_DEFS_SVH
`define SSIMON_DEFS_SVH

////////////////////////////////////////////////////////////////////////////////
// timing
`define SSIMON_CLK_MHZ      250
`define SSIMON_MIN_SSI_KHZ  70
// clock high longer than one period at the slowest legal rate ends a frame
`define SSIMON_GAP_CYC      ((`SSIMON_CLK_MHZ * 1000) / `SSIMON_MIN_SSI_KHZ)
`define SSIMON_CLK_LOSS_MS  10
`define SSIMON_FLASH_PER_MS 1000
`define SSIMON_FLASH_ON_MS  120
`define SSIMON_UPD0_US      500
`define SSIMON_UPD1_US      850
`define SSIMON_UPD2_US      1000
`define SSIMON_UPD3_US      2000
`define SSIMON_UPD4_US      4000

////////////////////////////////////////////////////////////////////////////////
// widths and reset values
`define SSIMON_SR_W         32
`define SSIMON_UPD_W        20
`define SSIMON_DLEN_RST     6'h18
`define SSIMON_NIRQ         5

////////////////////////////////////////////////////////////////////////////////
// register offsets
`define SSIMON_A_CTRL       8'h00
`define SSIMON_A_DLEN       8'h04
`define SSIMON_A_STATE      8'h08
`define SSIMON_A_ISTAT      8'h0C
`define SSIMON_A_IEN        8'h10
`define SSIMON_A_ICLR       8'h14
`define SSIMON_A_POS        8'h18

////////////////////////////////////////////////////////////////////////////////
// event bits
`define SSIMON_EV_CLK       0
`define SSIMON_EV_ELEM      1
`define SSIMON_EV_LEN       2
`define SSIMON_EV_SYNC      3
`define SSIMON_EV_FAULT     4

`endif

//--- ssimon_pkg.sv
`include "ssimon_defs.svh"

package ssimon_pkg;

    typedef enum logic {CAL_WAIT, CAL_DONE} ssimon_cal_e;

    typedef struct packed {
        ssimon_cal_e               cal;
        logic [7:0]                gain;
        logic                      clk_s1;
        logic                      clk_s2;
        logic                      clk_s3;
        logic                      elem_s1;
        logic                      elem_s2;
        logic                      elem_q;
        logic                      fault_q;
        logic [21:0]               loss_cnt;
        logic                      clk_ok;
        logic [11:0]               gap_cnt;
        logic                      in_frame;
        logic [6:0]                pulse_cnt;
        logic [`SSIMON_SR_W-1:0]   sr;
        logic                      data;
        logic                      len_err;
        logic                      sync_err;
        logic [1:0]                upd_cnt;
        logic [27:0]               flash_cnt;
        logic                      led_r;
        logic                      led_g;
        logic                      sync_mode;
        logic [2:0]                len_sel;
        logic [5:0]                data_len;
        logic [`SSIMON_NIRQ-1:0]   irq_stat;
        logic [`SSIMON_NIRQ-1:0]   irq_en;
        logic                      irq;
        logic [31:0]               rd_data;
    } ssimon_core_s;

    typedef struct packed {
        logic [`SSIMON_UPD_W-1:0]  cnt;
        logic                      stb;
        logic [`SSIMON_SR_W-1:0]   held;
    } ssimon_upd_s;

endpackage : ssimon_pkg

//--- ssimon_upd_if.sv
`timescale 1ns/1ps
`include "ssimon_defs.svh"

interface ssimon_upd_if;
    logic [2:0]               len_sel;
    logic [`SSIMON_SR_W-1:0]  meas_pos;
    logic                     stb;
    logic [`SSIMON_SR_W-1:0]  held_pos;

    modport core (output len_sel, output meas_pos, input stb, input held_pos);
    modport upd (input len_sel, input meas_pos, output stb, output held_pos);
endinterface : ssimon_upd_if

//--- ssimon_update.sv
`timescale 1ns/1ps
`include "ssimon_defs.svh"

module ssimon_update #(
    parameter logic [`SSIMON_UPD_W-1:0] UPD0_CYC = `SSIMON_UPD_W'(`SSIMON_UPD0_US * `SSIMON_CLK_MHZ),
    parameter logic [`SSIMON_UPD_W-1:0] UPD1_CYC = `SSIMON_UPD_W'(`SSIMON_UPD1_US * `SSIMON_CLK_MHZ),
    parameter logic [`SSIMON_UPD_W-1:0] UPD2_CYC = `SSIMON_UPD_W'(`SSIMON_UPD2_US * `SSIMON_CLK_MHZ),
    parameter logic [`SSIMON_UPD_W-1:0] UPD3_CYC = `SSIMON_UPD_W'(`SSIMON_UPD3_US * `SSIMON_CLK_MHZ),
    parameter logic [`SSIMON_UPD_W-1:0] UPD4_CYC = `SSIMON_UPD_W'(`SSIMON_UPD4_US * `SSIMON_CLK_MHZ)
) (
    // clock and reset
    input  logic              i_clk_sys,
    input  logic              i_rst,
    // core side
    ssimon_upd_if.upd         bus
);

    ssimon_pkg::ssimon_upd_s u_q;
    ssimon_pkg::ssimon_upd_s u_d;

    // longer probes need a longer refresh; unused codes fall back to the longest
    function automatic logic [`SSIMON_UPD_W-1:0] upd_limit(input logic [2:0] sel);
        case (sel)
            3'h0: upd_limit = UPD0_CYC;
            3'h1: upd_limit = UPD1_CYC;
            3'h2: upd_limit = UPD2_CYC;
            3'h3: upd_limit = UPD3_CYC;
            default: upd_limit = UPD4_CYC;
        endcase
    endfunction : upd_limit

    ////////////////////////////////////////////////////////////////////////////
    // [RULE12] periodic refresh, hold between
    always_comb begin
        u_d = u_q;
        u_d.stb = 1'b0;
        if (u_q.cnt >= upd_limit(bus.len_sel) - `SSIMON_UPD_W'(1)) begin
            u_d.cnt = '0;
            u_d.stb = 1'b1;
            u_d.held = bus.meas_pos;
        end else begin
            u_d.cnt = u_q.cnt + `SSIMON_UPD_W'(1);
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            u_q <= '0;
        end else begin
            u_q <= u_d;
        end
    end

    assign bus.stb      = u_q.stb;
    assign bus.held_pos = u_q.held;

    ////////////////////////////////////////////////////////////////////////////
    a_hold_pos: assert property (@(posedge i_clk_sys) disable iff (i_rst) // [RULE12]
        $changed(u_q.held) |-> u_q.stb)
        else $error("held position changed outside a refresh");

endmodule : ssimon_update

//--- ssimon_ssi_master.sv
`timescale 1ns/1ps

module ssimon_ssi_master (
    // link pins
    output logic      o_ssi_clk,
    input  wire logic i_ssi_data
);

    ////////////////////////////////////////////////////////////////////////////////
    // clock idles high and stands still between frames
    initial o_ssi_clk = 1'b1;

    ////////////////////////////////////////////////////////////////////////////////
    // master sets rate and length
    // hp is the half period in ns; data is taken late in the high phase
    task automatic frame(input int n, input int hp, output logic [31:0] w);
        w = 32'h0000_0000;
        // callers return on or just after a clock edge; keep pin changes off the edge
        #1;
        for (int i = 0; i < n; i++) begin
            o_ssi_clk = 1'b0;
            #(hp);
            o_ssi_clk = 1'b1;
            #(hp - 1);
            w = {w[30:0], i_ssi_data};
            #1;
        end
        // idle high past the frame-end gap so the device closes the frame
        #15000;
    endtask : frame

endmodule : ssimon_ssi_master

//--- ssimon_core_tb.sv
`timescale 1ns/1ps
`include "ssimon_defs.svh"

module ssimon_core_tb;

    logic        i_clk_sys;
    logic        i_rst;
    logic        ssi_clk;
    logic        ssi_data;
    logic        i_elem_present;
    logic [7:0]  i_sig_level;
    logic [23:0] i_meas_pos;
    logic        i_fault;
    logic        o_led_red;
    logic        o_led_green;
    logic [7:0]  o_gain;
    logic [7:0]  i_addr;
    logic [31:0] i_wdata;
    logic        i_wr;
    logic        i_rd;
    logic [31:0] o_rdata;
    logic        o_irq;
    int          error_cnt;
    int          n_compared;
    logic [31:0] w;

    ////////////////////////////////////////////////////////////////////////////////
    // short counts keep the run small
    ssimon_core #(
        .LOSS_CYC     (22'h2710),
        .FLASH_PER_CYC(28'h64),
        .FLASH_ON_CYC (28'hC),
        .UPD0_CYC     (20'h32),
        .UPD4_CYC     (20'hC8)
    ) u_ssimon_core (
        .i_clk_sys     (i_clk_sys),
        .i_rst         (i_rst),
        .i_ssi_clk     (ssi_clk),
        .o_ssi_data    (ssi_data),
        .i_elem_present(i_elem_present),
        .i_sig_level   (i_sig_level),
        .i_meas_pos    (i_meas_pos),
        .i_fault       (i_fault),
        .o_led_red     (o_led_red),
        .o_led_green   (o_led_green),
        .o_gain        (o_gain),
        .i_addr        (i_addr),
        .i_wdata       (i_wdata),
        .i_wr          (i_wr),
        .i_rd          (i_rd),
        .o_rdata       (o_rdata),
        .o_irq         (o_irq)
    );

    ssimon_ssi_master u_ssimon_ssi_master (
        .o_ssi_clk (ssi_clk),
        .i_ssi_data(ssi_data)
    );

    initial begin
        i_clk_sys = 1'b0;
        forever #2 i_clk_sys = ~i_clk_sys;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // helpers
    task automatic print_verdict;
        if (error_cnt == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : print_verdict

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic idle(input int n);
        repeat (n) @(posedge i_clk_sys);
    endtask : idle

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk_sys);
        i_wr    <= 1'b1;
        i_addr  <= a;
        i_wdata <= d;
        @(posedge i_clk_sys);
        i_wr    <= 1'b0;
    endtask : wr

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge i_clk_sys);
        i_rd   <= 1'b1;
        i_addr <= a;
        @(posedge i_clk_sys);
        i_rd   <= 1'b0;
        #1;
        d = o_rdata;
    endtask : rd

    task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] m,
                        input logic [31:0] e);
        rd(a, w);
        chk(nm, e, w & m);
    endtask : rchk

    // a whole flash period, so the count does not depend on phase
    task automatic leds(input int er, input int eg);
        int r;
        int g;
        r = 0;
        g = 0;
        repeat (100) begin
            @(posedge i_clk_sys);
            #1;
            if (o_led_red === 1'b1) r++;
            if (o_led_green === 1'b1) g++;
        end
        chk("led_red_cycles", 32'(er), 32'(r));
        chk("led_green_cycles", 32'(eg), 32'(g));
    endtask : leds

    task automatic frame_chk(input int n, input int hp, input logic [31:0] e);
        u_ssimon_ssi_master.frame(n, hp, w);
        chk("frame_word", e, w);
    endtask : frame_chk

    task automatic wait_pos(input logic [31:0] e);
        for (int i = 0; i < 300; i++) begin
            rd(`SSIMON_A_POS, w);
            if (w === e) return;
        end
        chk("pos_wait", e, w);
        print_verdict();
    endtask : wait_pos

    ////////////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_reset;
        rchk("dlen", `SSIMON_A_DLEN, 32'h0000_003F, 32'h0000_0018);
        rchk("ctrl", `SSIMON_A_CTRL, 32'hFFFF_FFFF, 32'h0000_0000);
        rchk("unmapped", 8'h1C, 32'hFFFF_FFFF, 32'h0000_0000);
        rchk("iclr", `SSIMON_A_ICLR, 32'hFFFF_FFFF, 32'h0000_0000);
        chk("irq_rst", 32'h0000_0000, 32'(o_irq));
    endtask : t_reset

    task automatic t_gain;
        idle(8);
        chk("gain", 32'h0000_005A, 32'(o_gain));
        i_sig_level <= 8'h33;
        idle(8);
        chk("gain_kept", 32'h0000_005A, 32'(o_gain));
        leds(100, 100);
    endtask : t_gain

    task automatic t_frame;
        idle(60);
        rchk("pos", `SSIMON_A_POS, 32'hFFFF_FFFF, 32'h00A5_C396);
        frame_chk(24, 40, 32'h00A5_C396);
        leds(0, 100);
        rchk("state_ok", `SSIMON_A_STATE, 32'h0000_000F, 32'h0000_000E);
    endtask : t_frame

    // measuring length code 4 gives a 200-cycle refresh here, four times that of code 0
    task automatic t_hold;
        wr(`SSIMON_A_CTRL, 32'h0000_0008);
        i_meas_pos <= 24'h12_3456;
        wait_pos(32'h0012_3456);
        i_meas_pos <= 24'h65_4321;
        idle(150);
        rchk("pos_held", `SSIMON_A_POS, 32'hFFFF_FFFF, 32'h0012_3456);
        wait_pos(32'h0065_4321);
        wr(`SSIMON_A_CTRL, 32'h0000_0000);
    endtask : t_hold

    // extra clocks shift zeros behind the position
    task automatic t_len;
        wr(`SSIMON_A_IEN, 32'h0000_0004);
        frame_chk(28, 40, 32'h0654_3210);
        rchk("istat_len", `SSIMON_A_ISTAT, 32'h0000_0004, 32'h0000_0004);
        chk("irq_len", 32'h0000_0001, 32'(o_irq));
        leds(100, 88);
        wr(`SSIMON_A_ICLR, 32'h0000_0004);
        rchk("istat_clr", `SSIMON_A_ISTAT, 32'h0000_0004, 32'h0000_0000);
        chk("irq_clr", 32'h0000_0000, 32'(o_irq));
        frame_chk(24, 40, 32'h0065_4321);
        leds(0, 100);
    endtask : t_len

    // many refreshes between reads breaks sync; slow master clock here
    task automatic t_sync;
        wr(`SSIMON_A_CTRL, 32'h0000_0001);
        frame_chk(24, 400, 32'h0065_4321);
        leds(12, 100);
        rchk("istat_sync", `SSIMON_A_ISTAT, 32'h0000_0008, 32'h0000_0008);
        wr(`SSIMON_A_CTRL, 32'h0000_0000);
        // sync mode off again; same slow master clock, no sync check, so steady green
        frame_chk(24, 400, 32'h0065_4321);
        leds(0, 100);
    endtask : t_sync

    task automatic t_elem;
        i_elem_present <= 1'b0;
        idle(10);
        leds(100, 0);
        frame_chk(24, 40, 32'h0000_0000);
        leds(100, 0);
        rchk("istat_elem", `SSIMON_A_ISTAT, 32'h0000_0002, 32'h0000_0002);
    endtask : t_elem

    task automatic t_fault;
        i_fault <= 1'b1;
        idle(4);
        leds(50, 0);
        rchk("istat_fault", `SSIMON_A_ISTAT, 32'h0000_0010, 32'h0000_0010);
        i_fault <= 1'b0;
    endtask : t_fault

    // loss time is the parameter set above
    task automatic t_loss;
        i_elem_present <= 1'b1;
        idle(10100);
        leds(100, 100);
        rchk("istat_loss", `SSIMON_A_ISTAT, 32'h0000_0001, 32'h0000_0001);
    endtask : t_loss

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        i_rst          = 1'b1;
        i_elem_present = 1'b1;
        i_sig_level    = 8'h5A;
        i_meas_pos     = 24'hA5_C396;
        i_fault        = 1'b0;
        i_addr         = 8'h00;
        i_wdata        = 32'h0000_0000;
        i_wr           = 1'b0;
        i_rd           = 1'b0;
        error_cnt      = 0;
        n_compared     = 0;
        idle(2);
        i_rst <= 1'b0;
        t_reset();
        t_gain();
        t_frame();
        t_hold();
        t_len();
        t_sync();
        t_elem();
        t_fault();
        t_loss();
        print_verdict();
    end

endmodule : ssimon_core_tb
